// ### src/sfip_regs.svh
// register offsets, field positions and reset values of the flag pin block
// Function
// - input pin read returns sampled pin level
// - masked input raises its request
// - output pin drives written data value
// - output pin read returns written value
// - write on masked output may raise request
// - reset gives inputs and masked requests
// - pin 7 request edge or level selectable
// - pins 6 and 5 level only
// - pin 4 request edge only
// - pins 3..0 mode only at reset
// - bus mode fixed, serial config writable
// - mode captured at reset release edge
// - mode bit 2 picks host memory mode
// - flag and request functions work together
`ifndef SFIP_REGS_SVH
`define SFIP_REGS_SVH
`define SFIP_OFS_DIR 8'h00
`define SFIP_OFS_VALUE 8'h04
`define SFIP_OFS_MASK 8'h08
`define SFIP_OFS_STATUS 8'h0C
`define SFIP_OFS_CTRL 8'h10
`define SFIP_OFS_MODE 8'h14
`define SFIP_CTRL_EDGE_BIT 0
`define SFIP_CTRL_SPORT_LSB 4
`define SFIP_MODE_HOST_BIT 2
`define SFIP_RST_DIR 8'h00
`define SFIP_RST_VALUE 8'h00
`define SFIP_RST_MASK 4'h0
`define SFIP_RST_LVL 8'hFF
`endif

// ### src/sfip_pkg.sv
// types of the flag pin block
package sfip_pkg;
    typedef enum logic {SFIP_CAPTURE, SFIP_RUN} sfip_phase_t;
    typedef struct packed {
        sfip_phase_t phase;
        logic [7:0] dir;
        logic [7:0] data;
        logic [3:0] mask;
        logic [3:0] status;
        logic edgeSel;
        logic [3:0] sportCfg;
        logic [3:0] mode;
        logic [7:0] prevLvl;
        logic [31:0] rdata;
    } sfip_state_t;
endpackage

// ### src/sfip_core.sv
// flag pins with shared requests and reset mode straps, APB register slave
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sfip_regs.svh"
module sfip_core import sfip_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // programmable flag pins
    input wire logic [7:0] flagPinIn,
    output logic [7:0] flagPinOut,
    output logic [7:0] flagPinOe,
    // requests toward vectoring and one summary line
    output logic edgeOrLevelRequest,
    output logic levelRequestOne,
    output logic levelRequestZero,
    output logic edgeOnlyRequest,
    output logic irq,
    // captured mode straps and written serial port config
    output logic [3:0] modeSelect,
    output logic modeValid,
    output logic hostMemoryMode,
    output logic [3:0] serialPortCfg
);

    sfip_state_t q;
    sfip_state_t d;
    logic [7:0] effLvl;
    logic [7:0] pinFall;
    logic [3:0] reqSet;
    logic [3:0] stsClr;
    logic apbWr;
    logic apbSetupRd;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // true when the address names an implemented word
    function automatic logic addrHit(input logic [7:0] a);
        addrHit = (a == `SFIP_OFS_DIR) || (a == `SFIP_OFS_VALUE) ||
            (a == `SFIP_OFS_MASK) || (a == `SFIP_OFS_STATUS) ||
            (a == `SFIP_OFS_CTRL) || (a == `SFIP_OFS_MODE);
    endfunction

    // read word for an address, unmapped reads as zero
    function automatic logic [31:0] readWord(input logic [7:0] a,
        input sfip_state_t s, input logic [7:0] pins);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `SFIP_OFS_DIR: w[7:0] = s.dir;
            `SFIP_OFS_VALUE: w[7:0] = (s.dir & s.data) | (~s.dir & pins);
            `SFIP_OFS_MASK: w[3:0] = s.mask;
            `SFIP_OFS_STATUS: w[3:0] = s.status;
            `SFIP_OFS_CTRL: begin
                w[`SFIP_CTRL_EDGE_BIT] = s.edgeSel;
                w[`SFIP_CTRL_SPORT_LSB +: 4] = s.sportCfg;
            end
            `SFIP_OFS_MODE: w[3:0] = s.mode;
            default: w = 32'h0000_0000;
        endcase
        readWord = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin levels and request events

    // an output pin reads back its own driven level, so a write can fire
    // the shared request exactly as an outside driver would
    assign effLvl = (q.dir & q.data) | (~q.dir & flagPinIn);
    assign pinFall = q.prevLvl & ~effLvl;

    // requests are active low; pin 7..4 feed requests 3..0
    always_comb begin
        reqSet[3] = q.edgeSel ? pinFall[7] : ~effLvl[7];
        reqSet[2] = ~effLvl[6];
        reqSet[1] = ~effLvl[5];
        reqSet[0] = pinFall[4];
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    // zero wait states: read word is latched in the setup cycle
    assign apbSetupRd = psel && !penable && !pwrite;
    assign apbWr = psel && penable && pwrite && addrHit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit(paddr);
    assign stsClr = (apbWr && paddr == `SFIP_OFS_STATUS) ? pwdata[3:0] : 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.prevLvl = effLvl;
        // a set in the same cycle as a write-one clear wins
        d.status = (q.status & ~stsClr) | reqSet;
        if (apbSetupRd) begin
            d.rdata = readWord(paddr, q, flagPinIn);
        end
        // straps sampled at the first edge after reset is released
        case (q.phase)
            SFIP_CAPTURE: begin
                d.mode = flagPinIn[3:0];
                d.phase = SFIP_RUN;
            end
            SFIP_RUN: d.phase = SFIP_RUN;
            default: d.phase = SFIP_RUN;
        endcase
        if (apbWr) begin
            case (paddr)
                `SFIP_OFS_DIR: d.dir = pwdata[7:0];
                `SFIP_OFS_VALUE: d.data = pwdata[7:0];
                `SFIP_OFS_MASK: d.mask = pwdata[3:0];
                `SFIP_OFS_CTRL: begin
                    d.edgeSel = pwdata[`SFIP_CTRL_EDGE_BIT];
                    // serial pins stay reconfigurable; mode has no write path
                    d.sportCfg = pwdata[`SFIP_CTRL_SPORT_LSB +: 4];
                end
                default: d.phase = d.phase;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // reset leaves every pin an input with all requests masked
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q.phase <= SFIP_CAPTURE;
            q.dir <= `SFIP_RST_DIR;
            q.data <= `SFIP_RST_VALUE;
            q.mask <= `SFIP_RST_MASK;
            q.status <= 4'h0;
            q.edgeSel <= 1'b0;
            q.sportCfg <= 4'h0;
            q.mode <= 4'h0;
            q.prevLvl <= `SFIP_RST_LVL;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata = q.rdata;
    assign flagPinOut = q.data & q.dir;
    assign flagPinOe = q.dir;
    // only masked-in requests reach vectoring and the summary line
    assign edgeOrLevelRequest = q.status[3] & q.mask[3];
    assign levelRequestOne = q.status[2] & q.mask[2];
    assign levelRequestZero = q.status[1] & q.mask[1];
    assign edgeOnlyRequest = q.status[0] & q.mask[0];
    assign irq = |(q.status & q.mask);
    assign modeSelect = q.mode;
    assign modeValid = (q.phase == SFIP_RUN);
    // bus function follows the strap: low full memory, high host memory
    assign hostMemoryMode = q.mode[`SFIP_MODE_HOST_BIT];
    assign serialPortCfg = q.sportCfg;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_value_read;
        psel && !penable && !pwrite && paddr == `SFIP_OFS_VALUE;
    endsequence

    property p_input_read;
        @(posedge ref_clk) disable iff (!nrst)
        s_value_read |=> ((prdata[7:0] & ~$past(q.dir)) ==
            ($past(flagPinIn) & ~$past(q.dir)));
    endproperty
    a_input_read: assert property (p_input_read)
        else $error("input pin read differs from pin level");

    property p_output_read;
        @(posedge ref_clk) disable iff (!nrst)
        s_value_read |=> ((prdata[7:0] & $past(q.dir)) ==
            ($past(q.data) & $past(q.dir)));
    endproperty
    a_output_read: assert property (p_output_read)
        else $error("output pin read differs from written value");

    property p_output_drive;
        @(posedge ref_clk) disable iff (!nrst)
        (psel && penable && pwrite && paddr == `SFIP_OFS_VALUE) |=>
            ((flagPinOut & flagPinOe) == ($past(pwdata[7:0]) & flagPinOe));
    endproperty
    a_output_drive: assert property (p_output_drive)
        else $error("written value not driven on output pins");

    property p_reset_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        !$past(nrst) |-> (flagPinOe == 8'h00 && !irq);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("pins not inputs or request live after reset");

    sequence s_level_low6;
        !q.dir[6] && !flagPinIn[6] && q.mask[2];
    endsequence

    property p_level_six;
        @(posedge ref_clk) disable iff (!nrst)
        s_level_low6 |=> q.status[2] && (levelRequestOne == q.mask[2]) &&
            (irq || !q.mask[2]);
    endproperty
    a_level_six: assert property (p_level_six)
        else $error("low level on pin 6 gave no request");

    property p_edge_four;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(q.status[0]) |-> $past(q.prevLvl[4]) && !$past(effLvl[4]);
    endproperty
    a_edge_four: assert property (p_edge_four)
        else $error("pin 4 request without falling edge");

    property p_edge_seven;
        @(posedge ref_clk) disable iff (!nrst)
        ($rose(q.status[3]) && $past(q.edgeSel)) |->
            $past(q.prevLvl[7]) && !$past(effLvl[7]);
    endproperty
    a_edge_seven: assert property (p_edge_seven)
        else $error("pin 7 edge mode fired without falling edge");

    property p_output_fires;
        @(posedge ref_clk) disable iff (!nrst)
        (q.dir[5] && !q.data[5] && q.mask[1]) |=> q.status[1] &&
            (levelRequestZero == q.mask[1]);
    endproperty
    a_output_fires: assert property (p_output_fires)
        else $error("low flag output on pin 5 gave no request");

    property p_mode_capture;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(modeValid) |-> modeSelect == $past(flagPinIn[3:0]);
    endproperty
    a_mode_capture: assert property (p_mode_capture)
        else $error("mode straps not taken at reset release");

    property p_mode_fixed;
        @(posedge ref_clk) disable iff (!nrst)
        (modeValid && $past(modeValid)) |-> $stable(modeSelect) &&
            $stable(hostMemoryMode);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed)
        else $error("mode changed while running");

    // a write-one clear with no fresh event in that cycle empties the bit
    sequence s_clear_idle;
        (stsClr & ~reqSet) != 4'h0;
    endsequence

    property p_status_clear;
        @(posedge ref_clk) disable iff (!nrst)
        s_clear_idle |=> (q.status & $past(stsClr & ~reqSet)) == 4'h0;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("write-one clear left a status bit set");

    // an event in the cycle of its own clear keeps the bit, so none is lost
    property p_set_wins;
        @(posedge ref_clk) disable iff (!nrst)
        ((stsClr & reqSet) != 4'h0) |=>
            ((q.status & $past(stsClr & reqSet)) == $past(stsClr & reqSet));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a request event in the same cycle");

    sequence s_level_low5;
        !q.dir[5] && !flagPinIn[5];
    endsequence

    property p_level_five;
        @(posedge ref_clk) disable iff (!nrst)
        s_level_low5 |=> q.status[1];
    endproperty
    a_level_five: assert property (p_level_five)
        else $error("low level on pin 5 gave no request");

    // pin 7 in level mode re-arms every cycle it is held low
    property p_level_seven;
        @(posedge ref_clk) disable iff (!nrst)
        (!q.edgeSel && !q.dir[7] && !flagPinIn[7]) |=> q.status[3];
    endproperty
    a_level_seven: assert property (p_level_seven)
        else $error("pin 7 level mode missed a low level");

    property p_edge_four_sets;
        @(posedge ref_clk) disable iff (!nrst)
        (q.prevLvl[4] && !effLvl[4]) |=> q.status[0];
    endproperty
    a_edge_four_sets: assert property (p_edge_four_sets)
        else $error("falling edge on pin 4 gave no request");

    // a pin parked low after its edge must not re-arm an edge-only request
    sequence s_held_low4;
        !q.prevLvl[4] && !effLvl[4] && stsClr[0];
    endsequence

    property p_edge_four_held;
        @(posedge ref_clk) disable iff (!nrst)
        s_held_low4 |=> !q.status[0];
    endproperty
    a_edge_four_held: assert property (p_edge_four_held)
        else $error("pin 4 held low re-set its edge request");

    property p_edge_seven_held;
        @(posedge ref_clk) disable iff (!nrst)
        (q.edgeSel && !q.prevLvl[7] && !effLvl[7] && stsClr[3]) |=> !q.status[3];
    endproperty
    a_edge_seven_held: assert property (p_edge_seven_held)
        else $error("pin 7 edge mode re-set while held low");

    property p_dir_drive;
        @(posedge ref_clk) disable iff (!nrst)
        (apbWr && paddr == `SFIP_OFS_DIR) |=> flagPinOe == $past(pwdata[7:0]);
    endproperty
    a_dir_drive: assert property (p_dir_drive)
        else $error("direction write not seen on pin enables");

    property p_serial_cfg;
        @(posedge ref_clk) disable iff (!nrst)
        (apbWr && paddr == `SFIP_OFS_CTRL) |=>
            serialPortCfg == $past(pwdata[`SFIP_CTRL_SPORT_LSB +: 4]);
    endproperty
    a_serial_cfg: assert property (p_serial_cfg)
        else $error("serial port setting not taken while running");

    property p_host_mode;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(modeValid) |-> hostMemoryMode == $past(flagPinIn[`SFIP_MODE_HOST_BIT]);
    endproperty
    a_host_mode: assert property (p_host_mode)
        else $error("memory mode does not follow its strap");

    // a low flag output on pin 6 reaches its level request like a driver would
    property p_out_six;
        @(posedge ref_clk) disable iff (!nrst)
        (q.dir[6] && !q.data[6]) |=> q.status[2];
    endproperty
    a_out_six: assert property (p_out_six)
        else $error("low flag output on pin 6 gave no request");

endmodule
`default_nettype wire

// ### dv/sfip_pin_model.sv
// partner model: external devices and pull-ups on the eight flag pins
`timescale 1ns/1ps
`default_nettype none
module sfip_pin_model (
    // pins from the block
    input wire logic [7:0] flagPinOut,
    input wire logic [7:0] flagPinOe,
    // external drivers commanded by the bench
    input wire logic [7:0] extOe,
    input wire logic [7:0] extLevel,
    // resolved pin levels
    output logic [7:0] flagPinIn
);
    // released pins go to the pull-up level, which keeps requests inactive
    assign flagPinIn = (flagPinOe & flagPinOut) | (~flagPinOe & extOe & extLevel)
        | (~flagPinOe & ~extOe);
endmodule
`default_nettype wire

// ### dv/shared_flag_interrupt_pins_tb.sv
// testbench of the flag pin block against a register-level model
`timescale 1ns/1ps
`default_nettype none
`include "sfip_regs.svh"
module shared_flag_interrupt_pins_tb;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
    logic modeValid, hostMemoryMode, irq, rqA, rqB, rqC, rqD;
    logic [7:0] paddr, flagPinIn, flagPinOut, flagPinOe, extOe, extLevel, ext, dirM, dataM;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] modeSelect, serialPortCfg;
    int err_total, comparisons, seed;

    sfip_core sfip_core_inst (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flagPinIn(flagPinIn), .flagPinOut(flagPinOut),
        .flagPinOe(flagPinOe), .edgeOrLevelRequest(rqA), .levelRequestOne(rqB),
        .levelRequestZero(rqC), .edgeOnlyRequest(rqD), .irq(irq), .modeSelect(modeSelect),
        .modeValid(modeValid), .hostMemoryMode(hostMemoryMode), .serialPortCfg(serialPortCfg));
    sfip_pin_model sfip_pin_model_inst (.flagPinOut(flagPinOut), .flagPinOe(flagPinOe),
        .extOe(extOe), .extLevel(extLevel), .flagPinIn(flagPinIn));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog; the limit is far above the roughly 165 cycles needed
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb master; entered just after a rising edge, holds until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, x, rd);
    endtask
    // a set bit pulls that upper pin low, a clear bit leaves it to the pull-up
    task drv(input logic [3:0] up);
        extOe <= {up, 4'hF};
        extLevel <= {4'h0, ext[3:0]};
        repeat (2) @(posedge ref_clk);
    endtask
    task final_report();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: straps, inputs, outputs, requests, refusals
    initial begin
        seed = 65703;
        err_total = 0;
        comparisons = 0;
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        extOe = 8'hFF;
        extLevel = 8'hF4;
        ext = 8'hF4;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk) extLevel <= 8'hFB;
        @(negedge ref_clk);
        chk("modeSelect", 32'h4, {28'h0, modeSelect});
        chk("hostMode", 32'h1, {31'h0, hostMemoryMode & modeValid});
        chk("pinOe", 32'h0, {24'h0, flagPinOe});
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge ref_clk);
        rdchk("mode", `SFIP_OFS_MODE, 32'h4);
        rdchk("dir", `SFIP_OFS_DIR, 32'h0);
        rdchk("mask", `SFIP_OFS_MASK, 32'h0);
        repeat (4) begin
            ext = {4'hF, 4'($random(seed))};
            extLevel <= ext;
            @(posedge ref_clk);
            rdchk("pinRead", `SFIP_OFS_VALUE, {24'h0, ext});
        end
        chk("modeHold", 32'h4, {28'h0, modeSelect});
        dirM = 8'h0F;
        dataM = 8'($random(seed));
        apb(1'b1, `SFIP_OFS_DIR, {24'h0, dirM});
        apb(1'b1, `SFIP_OFS_VALUE, {24'h0, dataM});
        chk("pinOut", {24'h0, dirM & dataM}, {24'h0, flagPinOut & flagPinOe});
        rdchk("mixed", `SFIP_OFS_VALUE, {24'h0, (dirM & dataM) | (~dirM & ext)});
        apb(1'b1, `SFIP_OFS_DIR, 32'h0);
        apb(1'b1, `SFIP_OFS_MASK, 32'hF);
        apb(1'b1, `SFIP_OFS_CTRL, 32'hA1);
        chk("serialCfg", 32'hA, {28'h0, serialPortCfg});
        drv(4'h0);
        for (int k = 0; k < 4; k++) begin
            drv(4'(1 << k));
            rdchk("status", `SFIP_OFS_STATUS, 32'(1 << k));
            chk("request", 32'(1 << k), {28'h0, rqA, rqB, rqC, rqD});
            chk("irqOn", 32'h1, {31'h0, irq});
            apb(1'b1, `SFIP_OFS_STATUS, 32'(1 << k));
            rdchk("held", `SFIP_OFS_STATUS, (k == 1 || k == 2) ? 32'(1 << k) : 32'h0);
            drv(4'h0);
            apb(1'b1, `SFIP_OFS_STATUS, 32'hF);
        end
        // pin 7 switched to level sensing re-sets while held low
        apb(1'b1, `SFIP_OFS_CTRL, 32'h0);
        drv(4'h8);
        apb(1'b1, `SFIP_OFS_STATUS, 32'h8);
        rdchk("level7", `SFIP_OFS_STATUS, 32'h8);
        apb(1'b1, `SFIP_OFS_MASK, 32'h0);
        chk("masked", 32'h0, {31'h0, irq});
        drv(4'h0);
        apb(1'b1, `SFIP_OFS_STATUS, 32'hF);
        // output writes alone fire the requests of pins 5 and 6; mask only gates
        apb(1'b1, `SFIP_OFS_MASK, 32'h2);
        apb(1'b1, `SFIP_OFS_DIR, 32'h60);
        apb(1'b1, `SFIP_OFS_VALUE, 32'h0);
        @(negedge ref_clk);
        chk("outIrq", 32'h1, {31'h0, irq & rqC});
        chk("outMasked", 32'h0, {31'h0, rqB});
        @(posedge ref_clk);
        rdchk("outSts", `SFIP_OFS_STATUS, 32'h6);
        apb(1'b1, `SFIP_OFS_MODE, 32'h0);
        rdchk("modeRo", `SFIP_OFS_MODE, 32'h4);
        chk("okResp", 32'h0, {31'h0, e});
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        chk("unmapped", 32'h0, rd);
        // a second reset in mid-run takes fresh straps, here full memory mode
        extOe <= 8'hFF;
        extLevel <= 8'hF0;
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("modeLow", 32'h0, {28'h0, modeSelect});
        chk("fullMode", 32'h1, {31'h0, ~hostMemoryMode & modeValid});
        chk("pinOeRst", 32'h0, {24'h0, flagPinOe});
        chk("irqRst", 32'h0, {31'h0, irq});
        @(posedge ref_clk);
        rdchk("modeReg", `SFIP_OFS_MODE, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
